// ==== dv/pol_voltage_setpoint_regs_test.sv ====
// Bench joining host controller and setpoint bank over the link.
// Assumes package, interface and design modules compiled first.
`timescale 1ns/100ps
module pol_voltage_setpoint_regs_test;
  import pvs_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic pok = 1'b0;
  logic con, wq;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdv, q;
  logic [15:0] vin = 16'h0, vt, mh, ml, fr;
  logic [23:0] fref;
  int err_count = 0, total_checks = 0, cyc = 0;
  pvs_if link ();
  pvs_host pvs_host_inst (.link(link.host), .mclk(mclk),
    .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdv),
    .avs_waitrequest(wq));
  pvs_device pvs_device_inst (.link(link.device), .mclk(mclk),
    .reset_n(reset_n), .vin_code(vin), .power_ok(pok),
    .conversion_on(con), .vout_target(vt), .margin_high(mh),
    .margin_low(ml), .fb_ratio(fr), .feedback_ref(fref));
  pvs_properties pvs_properties_inst (.mclk(mclk), .reset_n(reset_n),
    .req(link.req), .we(link.we), .code(link.code),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
  // Clock
  always #10 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chkv(string n, logic [23:0] g, logic [23:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chkv
  task automatic chkb(string n, logic g, logic e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : chkb
  // One Avalon access, held until waitrequest is seen low
  task automatic av(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do
      @(posedge mclk);
    while (wq !== 1'b0);
    q = rdv;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av
  // One link command through the controller registers
  task automatic cmd(logic w, logic [7:0] c, logic [15:0] d);
    av(1'b1, HOST_WDATA_OFF, {16'h0000, d});
    av(1'b1, HOST_CMD_OFF, {23'h000000, w, c});
    do
      av(1'b0, HOST_STATUS_OFF, 32'h0);
    while (q[STAT_BUSY_BIT] !== 1'b0 || q[STAT_DONE_BIT] !== 1'b1);
    av(1'b0, HOST_RDATA_OFF, 32'h0);
  endtask : cmd
  task automatic rchk(string n, logic [7:0] c, logic [15:0] e);
    cmd(1'b0, c, 16'h0000);
    chkv(n, q[23:0], {8'h00, e});
  endtask : rchk
  task automatic step(logic [15:0] v, logic p, logic e);
    vin <= v;
    pok <= p;
    repeat (4) @(posedge mclk);
    chkb("conversion", con, e);
  endtask : step
  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 3; i++)
      rchk("reset word", REG_CODE[i], REG_RST[i]);
    for (int i = 3; i < NUM_REGS; i++)
      rchk("reset word", REG_CODE[i], REG_RST[i]);
    chkv("vout reset", {8'h00, vt}, 24'h00015E);
    chkv("margin high", {8'h00, mh}, 24'h000181);
    chkv("margin low", {8'h00, ml}, 24'h00013B);
    chkv("ratio", {8'h00, fr}, 24'h000359);
    chkv("fb ref", fref, 24'h00015E * 24'h000359);
    rchk("format", CMD_VOUT_MODE, 16'h0040);
    cmd(1'b1, CMD_VOUT_MODE, 16'h0000);
    rchk("format kept", CMD_VOUT_MODE, 16'h0040);
    rchk("unknown", 8'h22, 16'h0000);
    av(1'b0, 4'h2, 32'h0);
    chkv("unmapped", q[23:0], 24'h000000);
    cmd(1'b1, CMD_VOUT_TARGET, 16'hF2BC);
    rchk("vout masked", CMD_VOUT_TARGET, 16'h02BC);
    chkv("vout", {8'h00, vt}, 24'h0002BC);
    cmd(1'b1, CMD_FB_RATIO, 16'h03E8);
    chkv("ratio new", {8'h00, fr}, 24'h0003E8);
    chkv("fb ref new", fref, 24'h0002BC * 24'h0003E8);
    cmd(1'b1, CMD_MARGIN_HIGH, 16'h0190);
    chkv("margin high new", {8'h00, mh}, 24'h000190);
    cmd(1'b1, CMD_MARGIN_LOW, 16'h0120);
    chkv("margin low new", {8'h00, ml}, 24'h000120);
    cmd(1'b1, CMD_START_TH, 16'h003D);
    rchk("start refused", CMD_START_TH, 16'h001D);
    cmd(1'b1, CMD_STOP_TH, 16'h001A);
    rchk("stop refused", CMD_STOP_TH, 16'h001B);
    step(16'h001C, 1'b1, 1'b0);
    step(16'h001D, 1'b1, 1'b1);
    step(16'h001C, 1'b1, 1'b1);
    step(16'h001B, 1'b1, 1'b0);
    step(16'h001D, 1'b0, 1'b0);
    cmd(1'b1, CMD_START_TH, 16'h003C);
    rchk("start top", CMD_START_TH, 16'h003C);
    cmd(1'b1, CMD_STOP_TH, 16'h0020);
    rchk("stop set", CMD_STOP_TH, 16'h0020);
    end_of_test();
  end
endmodule : pol_voltage_setpoint_regs_test

// ==== dv/pvs_properties.sv ====
// Checker of the command link between host and setpoint bank.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
module pvs_properties (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req,
  input wire logic we,
  input wire logic [pvs_pkg::CW-1:0] code,
  input wire logic [pvs_pkg::DW-1:0] wdata,
  input wire logic [pvs_pkg::DW-1:0] rdata,
  input wire logic ack
);
  import pvs_pkg::*;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Read answers and mapped codes
  logic rd_ack;
  logic known;
  assign rd_ack = ack && !we;
  assign known = code inside {CMD_VOUT_MODE, CMD_VOUT_TARGET,
    CMD_MARGIN_HIGH, CMD_MARGIN_LOW, CMD_FB_RATIO, CMD_START_TH,
    CMD_STOP_TH};
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_follows: assert property (req && !ack |=> ack)
    else $error("ack missing after request");
  chk_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without request");
  chk_format_read: assert property
    (rd_ack && code == CMD_VOUT_MODE |-> rdata == 16'h0040)
    else $error("format byte wrong");
  chk_upper_zero: assert property (rd_ack |-> rdata[15:12] == 4'h0)
    else $error("upper bits not zero");
  chk_start_range: assert property
    (rd_ack && code == CMD_START_TH |-> rdata inside {[START_MIN:TH_MAX]})
    else $error("start threshold out of range");
  chk_stop_range: assert property
    (rd_ack && code == CMD_STOP_TH |-> rdata inside {[STOP_MIN:TH_MAX]})
    else $error("stop threshold out of range");
  chk_unknown_zero: assert property
    (rd_ack && !known |-> rdata == 16'h0)
    else $error("unknown code not zero");
endmodule : pvs_properties

// ==== src/pvs_device.sv ====
// Voltage setpoint register bank of a point-of-load converter.
// Assumes the input-voltage code and power_ok come from logic on mclk.
// How it works
// - Output target 2 mV/count, default 0x015E
// - Feedback reference is target times divider ratio
// - Margin-high target 2 mV/count, default 0x0181
// - Margin-low target 2 mV/count, default 0x013B
// - Divider ratio 0.001/count, default 0x0359
// - Host programs ratio matching real divider
// - Start converting at start threshold, conditions met
// - Start threshold 250 mV/count, 7.25-15 V, 0x001D
// - Stop converting when input falls to stop
// - Stop threshold 250 mV/count, 6.75-15 V, 0x001B
// - Host keeps start above stop with margin; the bank does not check it and takes any legal pair, even stop above start
// - Output format byte reads 0x40
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module pvs_device (
  pvs_if.device link,
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [pvs_pkg::DW-1:0] vin_code,
  input wire logic power_ok,
  output logic conversion_on,
  output logic [pvs_pkg::DW-1:0] vout_target,
  output logic [pvs_pkg::DW-1:0] margin_high,
  output logic [pvs_pkg::DW-1:0] margin_low,
  output logic [pvs_pkg::DW-1:0] fb_ratio,
  output logic [pvs_pkg::FB_REF_W-1:0] feedback_ref
);
  import pvs_pkg::*;

  typedef struct packed {
    logic ack;
    logic [DW-1:0] rdata;
    logic run;
    logic [FB_REF_W-1:0] fb_ref;
  } pvs_dev_s;

  pvs_dev_s state_reg;
  pvs_dev_s state_next;

  logic [NUM_REGS-1:0][DW-1:0] word;
  logic [NUM_REGS-1:0] wr_sel;
  logic take;
  logic [DW-1:0] masked;

  // Threshold codes outside the legal span are refused
  function automatic logic code_ok(input int idx, input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    if (idx == IDX_START)
    begin
      ok = (v >= START_MIN) && (v <= TH_MAX);
    end
    else if (idx == IDX_STOP)
    begin
      ok = (v >= STOP_MIN) && (v <= TH_MAX);
    end
    return ok;
  endfunction : code_ok

  // A request is taken once, on its first cycle
  assign take = link.req && !state_reg.ack;
  assign masked = link.wdata & WR_MASK;

  // Write strobes; threshold words also need a legal code
  assign wr_sel[IDX_VOUT] = take && link.we
    && (link.code == CMD_VOUT_TARGET);
  assign wr_sel[IDX_MHIGH] = take && link.we
    && (link.code == CMD_MARGIN_HIGH);
  assign wr_sel[IDX_MLOW] = take && link.we
    && (link.code == CMD_MARGIN_LOW);
  assign wr_sel[IDX_RATIO] = take && link.we
    && (link.code == CMD_FB_RATIO);
  assign wr_sel[IDX_START] = take && link.we
    && (link.code == CMD_START_TH) && code_ok(IDX_START, masked);
  assign wr_sel[IDX_STOP] = take && link.we
    && (link.code == CMD_STOP_TH) && code_ok(IDX_STOP, masked);

  // Output-voltage target word
  pvs_word_reg #(
    .RESET_VAL(RST_VOUT_TARGET),
    .MASK(WR_MASK)
  ) u_vout_target (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_en(wr_sel[IDX_VOUT]),
    .wdata(link.wdata),
    .value(word[IDX_VOUT])
  );

  // Margin-high target word
  pvs_word_reg #(
    .RESET_VAL(RST_MARGIN_HIGH),
    .MASK(WR_MASK)
  ) u_margin_high (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_en(wr_sel[IDX_MHIGH]),
    .wdata(link.wdata),
    .value(word[IDX_MHIGH])
  );

  // Margin-low target word
  pvs_word_reg #(
    .RESET_VAL(RST_MARGIN_LOW),
    .MASK(WR_MASK)
  ) u_margin_low (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_en(wr_sel[IDX_MLOW]),
    .wdata(link.wdata),
    .value(word[IDX_MLOW])
  );

  // Feedback divider ratio word
  pvs_word_reg #(
    .RESET_VAL(RST_FB_RATIO),
    .MASK(WR_MASK)
  ) u_fb_ratio (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_en(wr_sel[IDX_RATIO]),
    .wdata(link.wdata),
    .value(word[IDX_RATIO])
  );

  // Start threshold word
  pvs_word_reg #(
    .RESET_VAL(RST_START_TH),
    .MASK(WR_MASK)
  ) u_start_th (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_en(wr_sel[IDX_START]),
    .wdata(link.wdata),
    .value(word[IDX_START])
  );

  // Stop threshold word
  pvs_word_reg #(
    .RESET_VAL(RST_STOP_TH),
    .MASK(WR_MASK)
  ) u_stop_th (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_en(wr_sel[IDX_STOP]),
    .wdata(link.wdata),
    .value(word[IDX_STOP])
  );

  // Link answer, conversion gate and feedback reference
  always_comb
  begin
    state_next = state_reg;
    state_next.ack = take;
    if (take && !link.we)
    begin
      state_next.rdata = '0;
      if (link.code == CMD_VOUT_MODE)
      begin
        state_next.rdata = {8'h00, VOUT_MODE_VAL};
      end
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (link.code == REG_CODE[i])
        begin
          state_next.rdata = word[i];
        end
      end
    end
    if (!state_reg.run)
    begin
      if (power_ok && (vin_code >= word[IDX_START]))
      begin
        state_next.run = 1'b1;
      end
    end
    else if (!power_ok || (vin_code <= word[IDX_STOP]))
    begin
      state_next.run = 1'b0;
    end
    // 12 x 12 bit product, 2 uV per count
    state_next.fb_ref = FB_REF_W'(word[IDX_VOUT][11:0]
      * word[IDX_RATIO][11:0]);
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign link.ack = state_reg.ack;
  assign link.rdata = state_reg.rdata;
  assign conversion_on = state_reg.run;
  assign vout_target = word[IDX_VOUT];
  assign margin_high = word[IDX_MHIGH];
  assign margin_low = word[IDX_MLOW];
  assign fb_ratio = word[IDX_RATIO];
  assign feedback_ref = state_reg.fb_ref;

endmodule : pvs_device

// ==== src/pvs_host.sv ====
// Host controller: takes orders over Avalon-MM, runs link commands.
// Assumes software loads WDATA before writing CMD, then polls STATUS.
`timescale 1ns/100ps
module pvs_host (
  pvs_if.host link,
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [pvs_pkg::AV_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import pvs_pkg::*;

  typedef struct packed {
    logic resp;
    logic [31:0] av_rdata;
    logic req;
    logic we;
    logic [CW-1:0] code;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic done;
  } pvs_host_s;

  pvs_host_s state_reg;
  pvs_host_s state_next;

  logic acc;

  // Every access waits exactly one cycle
  assign acc = avs_read || avs_write;
  assign avs_waitrequest = acc && !state_reg.resp;

  // Bus slave and link master
  always_comb
  begin
    state_next = state_reg;
    state_next.resp = acc && !state_reg.resp;
    // Read data captured in the waiting cycle
    if (avs_read && !state_reg.resp)
    begin
      state_next.av_rdata = '0;
      case (avs_address)
        HOST_CMD_OFF: state_next.av_rdata =
          {23'h000000, state_reg.we, state_reg.code};
        HOST_WDATA_OFF: state_next.av_rdata = {16'h0000, state_reg.wdata};
        HOST_STATUS_OFF: state_next.av_rdata =
          {30'h00000000, state_reg.done, state_reg.req};
        HOST_RDATA_OFF: state_next.av_rdata = {16'h0000, state_reg.rdata};
        default: state_next.av_rdata = '0;
      endcase
    end
    // Writes land at the edge where waitrequest is low; refused if busy
    if (avs_write && state_reg.resp && !state_reg.req)
    begin
      case (avs_address)
        HOST_CMD_OFF:
        begin
          state_next.req = 1'b1;
          state_next.we = avs_writedata[CMD_WRITE_BIT];
          state_next.code = avs_writedata[CW-1:0];
          state_next.done = 1'b0;
        end
        HOST_WDATA_OFF: state_next.wdata = avs_writedata[DW-1:0];
        default: state_next.req = state_reg.req;
      endcase
    end
    // Link answer ends the command
    if (state_reg.req && link.ack)
    begin
      state_next.req = 1'b0;
      state_next.done = 1'b1;
      if (!state_reg.we)
      begin
        state_next.rdata = link.rdata;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign avs_readdata = state_reg.av_rdata;
  assign link.req = state_reg.req;
  assign link.we = state_reg.we;
  assign link.code = state_reg.code;
  assign link.wdata = state_reg.wdata;

endmodule : pvs_host

// ==== src/pvs_if.sv ====
// Command link between the host controller and the setpoint bank.
// Assumes both ends run on the same mclk; no clocking here.
`timescale 1ns/100ps
interface pvs_if;
  logic req;
  logic we;
  logic [pvs_pkg::CW-1:0] code;
  logic [pvs_pkg::DW-1:0] wdata;
  logic [pvs_pkg::DW-1:0] rdata;
  logic ack;

  // Bank end
  modport device (input req, input we, input code, input wdata,
    output rdata, output ack);
  // Controller end
  modport host (output req, output we, output code, output wdata,
    input rdata, input ack);
endinterface : pvs_if

// ==== src/pvs_pkg.sv ====
// Constants for the voltage setpoint register bank and its host controller.
// Assumes one 50 MHz clock shared by both ends of the link.
package pvs_pkg;

  // Command word widths
  localparam int DW = 16;
  localparam int CW = 8;
  localparam int NUM_REGS = 6;
  localparam int FB_REF_W = 24;

  // Command codes of the bank
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_VOUT_TARGET = 8'h21;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_FB_RATIO = 8'h29;
  localparam logic [7:0] CMD_START_TH = 8'h35;
  localparam logic [7:0] CMD_STOP_TH = 8'h36;

  // Power-on values
  localparam logic [7:0] VOUT_MODE_VAL = 8'h40;
  localparam logic [15:0] RST_VOUT_TARGET = 16'h015E;
  localparam logic [15:0] RST_MARGIN_HIGH = 16'h0181;
  localparam logic [15:0] RST_MARGIN_LOW = 16'h013B;
  localparam logic [15:0] RST_FB_RATIO = 16'h0359;
  localparam logic [15:0] RST_START_TH = 16'h001D;
  localparam logic [15:0] RST_STOP_TH = 16'h001B;

  // Writable field of every command word; bits 15..12 read as zero
  localparam logic [15:0] WR_MASK = 16'h0FFF;

  // Legal threshold codes, 250 mV per count
  localparam logic [15:0] START_MIN = 16'h001D;
  localparam logic [15:0] STOP_MIN = 16'h001B;
  localparam logic [15:0] TH_MAX = 16'h003C;

  // Bank index of each command word
  localparam int IDX_VOUT = 0;
  localparam int IDX_MHIGH = 1;
  localparam int IDX_MLOW = 2;
  localparam int IDX_RATIO = 3;
  localparam int IDX_START = 4;
  localparam int IDX_STOP = 5;

  // Tables by index, index 0 rightmost
  localparam logic [NUM_REGS-1:0][7:0] REG_CODE = {CMD_STOP_TH,
    CMD_START_TH, CMD_FB_RATIO, CMD_MARGIN_LOW, CMD_MARGIN_HIGH,
    CMD_VOUT_TARGET};
  localparam logic [NUM_REGS-1:0][15:0] REG_RST = {RST_STOP_TH,
    RST_START_TH, RST_FB_RATIO, RST_MARGIN_LOW, RST_MARGIN_HIGH,
    RST_VOUT_TARGET};

  // Host controller Avalon map, byte addresses
  localparam int AV_AW = 4;
  localparam logic [3:0] HOST_CMD_OFF = 4'h0;
  localparam logic [3:0] HOST_WDATA_OFF = 4'h4;
  localparam logic [3:0] HOST_STATUS_OFF = 4'h8;
  localparam logic [3:0] HOST_RDATA_OFF = 4'hC;
  localparam int CMD_WRITE_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

endpackage : pvs_pkg

// ==== src/pvs_word_reg.sv ====
// One 16-bit command word with a write mask and a power-on value.
// Assumes the write strobe comes from logic on mclk.
`timescale 1ns/100ps
module pvs_word_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] MASK = 16'h0FFF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [pvs_pkg::DW-1:0] wdata,
  output logic [pvs_pkg::DW-1:0] value
);
  import pvs_pkg::*;

  typedef struct packed {
    logic [DW-1:0] value;
  } pvs_word_s;

  pvs_word_s state_reg;
  pvs_word_s state_next;

  // Masked load; read-only bits never take a one
  always_comb
  begin
    state_next = state_reg;
    if (wr_en)
    begin
      state_next.value = wdata & MASK;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= RESET_VAL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.value;

endmodule : pvs_word_reg
